/* logic/ccs_defs.svh */
// Constants for the codec clock and lock register bank.
// Assumes an 8-bit DSP I/O port with one-cycle read and write strobes.
// Summary of operation
// - Clock at 5, locks at 6 and 7.
// - Bit 7 picks oscillator, default slower.
// - Route 00 divides by two times (divisor plus one).
// - Route picks divided, x1, halved, third.
// - Clock bits 6 and 5 read zero.
// - Fifteen tabulated sample rates are reachable.
// - Master clock is 256 times sample rate.
// - Bit clock x64, frame clock at rate.
// - Lock is bit 0; bits 7:1 read zero.
// - Lock bit reads 1 only when DSP owns.
// - Pending request wins when host releases.
// - Writing 0 cancels request and releases ownership.
// - Lock bits read 0 after reset.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
// Register addresses on the DSP I/O port
`define CCS_ADDR_CLK      16'h0005
`define CCS_ADDR_LOCK0    16'h0006
`define CCS_ADDR_LOCK1    16'h0007
// Field positions of the clock control register
`define CCS_OSC_BIT       7
`define CCS_DIV_HI        4
`define CCS_DIV_LO        2
`define CCS_ROUTE_HI      1
`define CCS_ROUTE_LO      0
// Writable bits of the clock register; 6 and 5 are reserved
`define CCS_CLK_WMASK     8'h9F
// Reset values
`define CCS_CLK_RST       8'h00
`define CCS_LOCK_RST      2'h0
// Route codes
`define CCS_ROUTE_DIV     2'h0
`define CCS_ROUTE_X1      2'h1
`define CCS_ROUTE_HALF    2'h2
`define CCS_ROUTE_THIRD   2'h3
// Master period counter bits that drive the bit clock and the frame clock
`define CCS_BIT_SEL       1
`define CCS_FRAME_SEL     7
`endif

/* logic/ccs_pkg.sv */
// Types shared by the codec clock and lock register bank.
// Assumes the constants header is compiled alongside.
package ccs_pkg;
  // Whole state of the clock generator
  typedef struct packed {
    logic       src_q;   // Source level seen last cycle
    logic [3:0] cnt;     // Source edges within one master period
    logic       mclk;    // Master clock level
    logic [7:0] bcnt;    // Master periods within one frame
  } ccs_gen_s;
  // Whole state of the register bank
  typedef struct packed {
    logic [7:0] ctl;       // Clock control register
    logic [1:0] dsp_own;   // DSP holds lock
    logic [1:0] host_own;  // Host holds lock
    logic [1:0] pend;      // DSP request waiting
    logic [7:0] rdata;     // Read data latch
  } ccs_reg_s;
endpackage : ccs_pkg

/* logic/ccs_clkgen.sv */
// Codec master, bit and frame clock generator.
// Assumes the oscillator inputs are sampled as synchronous levels on clk.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_clkgen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       osc_a,
  input  wire logic       osc_b,
  input  wire logic       sel,
  input  wire logic [2:0] div,
  input  wire logic [1:0] route,
  output logic            mclk,
  output logic            sclk,
  output logic            lrclk
);
  ccs_pkg::ccs_gen_s s_r;    // Registered state
  ccs_pkg::ccs_gen_s s_nxt;  // Next state
  logic              src;    // Chosen oscillator level
  logic              edge_s; // Rising edge of the chosen oscillator
  logic [4:0]        n;      // Source edges per master period

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    src    = sel ? osc_b : osc_a;
    edge_s = src & ~s_r.src_q;
    unique case (route)
      `CCS_ROUTE_DIV:   n = {({1'b0, div} + 4'h1), 1'b0};
      `CCS_ROUTE_X1:    n = 5'h01;
      `CCS_ROUTE_HALF:  n = 5'h02;
      `CCS_ROUTE_THIRD: n = 5'h03;
    endcase
    s_nxt       = s_r;
    s_nxt.src_q = src;
    // Count source edges; wrap at the period length
    if (edge_s) begin
      s_nxt.cnt = ({1'b0, s_r.cnt} >= n - 5'h01) ? 4'h0 : s_r.cnt + 4'h1;
    end
    // x1 passes the source straight on; odd ratios are not 50 percent duty
    if (n == 5'h01) begin
      s_nxt.mclk = src;
    end else begin
      s_nxt.mclk = s_nxt.cnt < n[4:1];
    end
    // Bit and frame clocks are taps of a master period counter
    if (s_nxt.mclk && !s_r.mclk) begin
      s_nxt.bcnt = s_r.bcnt + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mclk  = s_r.mclk;
  assign sclk  = s_r.bcnt[`CCS_BIT_SEL];
  assign lrclk = s_r.bcnt[`CCS_FRAME_SEL];

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_div_wrap_zero: assert property ((edge_s && n > 5'h01 && {1'b0, s_r.cnt} == n - 5'h01) |=> s_r.cnt == 4'h0)
    else $error("divider did not wrap");
  a_sclk_on_mclk: assert property ($changed(sclk) |-> $rose(mclk))
    else $error("bit clock moved without master edge");
  a_frame_on_bit: assert property ($changed(lrclk) |-> $fell(sclk))
    else $error("frame clock moved off bit clock fall");
endmodule : ccs_clkgen

/* logic/ccs_regs.sv */
// Codec clock control and two shared hardware locks on the DSP I/O port.
// Assumes single-cycle IO_WR / IO_RD strobes and a host that holds
// HOST_LOCK_REQ high for as long as it wants the lock.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_regs (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic [7:0]  IO_WDATA,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  output logic      [7:0]  IO_RDATA,
  input  wire logic        OSC_24M,
  input  wire logic        OSC_33M,
  input  wire logic [1:0]  HOST_LOCK_REQ,
  output logic      [1:0]  HOST_LOCK_GRANT,
  output logic             CODEC_MCLK,
  output logic             CODEC_SCLK,
  output logic             CODEC_LRCLK
);
  ccs_pkg::ccs_reg_s s_r;    // Registered state
  ccs_pkg::ccs_reg_s s_nxt;  // Next state
  logic [1:0]        lock_wr; // Write strobe per lock
  logic              clk_wr;  // Write strobe of clock register

  //////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    clk_wr     = IO_WR && (IO_ADDR == `CCS_ADDR_CLK);
    lock_wr[0] = IO_WR && (IO_ADDR == `CCS_ADDR_LOCK0);
    lock_wr[1] = IO_WR && (IO_ADDR == `CCS_ADDR_LOCK1);
  end

  //////////////////////////////////////////////////////////////////////
  // Next state of registers and locks
  always_comb begin
    s_nxt = s_r;
    // Reserved bits never store, so they always read back zero
    if (clk_wr) begin
      s_nxt.ctl = IO_WDATA & `CCS_CLK_WMASK;
    end
    for (int i = 0; i < 2; i++) begin
      // DSP side: 1 asks for the lock, 0 cancels and releases
      if (lock_wr[i]) begin
        if (IO_WDATA[0]) begin
          s_nxt.pend[i] = ~s_r.dsp_own[i];
        end else begin
          s_nxt.pend[i]    = 1'b0;
          s_nxt.dsp_own[i] = 1'b0;
        end
      end
      // Host lets go as soon as it drops its request
      if (s_r.host_own[i] && !HOST_LOCK_REQ[i]) begin
        s_nxt.host_own[i] = 1'b0;
      end
      // Free lock: a waiting DSP request wins a tie with the host
      if (!s_nxt.dsp_own[i] && !s_nxt.host_own[i]) begin
        if (s_nxt.pend[i]) begin
          s_nxt.dsp_own[i] = 1'b1;
          s_nxt.pend[i]    = 1'b0;
        end else if (HOST_LOCK_REQ[i]) begin
          s_nxt.host_own[i] = 1'b1;
        end
      end
    end
    // Read data: latched on the strobe, zero for unmapped addresses
    if (IO_RD) begin
      unique case (IO_ADDR)
        `CCS_ADDR_CLK:   s_nxt.rdata = s_r.ctl;
        `CCS_ADDR_LOCK0: s_nxt.rdata = {7'h00, s_r.dsp_own[0]};
        `CCS_ADDR_LOCK1: s_nxt.rdata = {7'h00, s_r.dsp_own[1]};
        default:         s_nxt.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register; everything clears, so the locks start unowned
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r          <= '0;
      s_r.ctl      <= `CCS_CLK_RST;
      s_r.dsp_own  <= `CCS_LOCK_RST;
      s_r.pend     <= `CCS_LOCK_RST;
      s_r.host_own <= `CCS_LOCK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign IO_RDATA        = s_r.rdata;
  assign HOST_LOCK_GRANT = s_r.host_own;

  //////////////////////////////////////////////////////////////////////
  // Clock generator driven by the control register
  ccs_clkgen u_gen (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .osc_a (OSC_24M),
    .osc_b (OSC_33M),
    .sel   (s_r.ctl[`CCS_OSC_BIT]),
    .div   (s_r.ctl[`CCS_DIV_HI:`CCS_DIV_LO]),
    .route (s_r.ctl[`CCS_ROUTE_HI:`CCS_ROUTE_LO]),
    .mclk  (CODEC_MCLK),
    .sclk  (CODEC_SCLK),
    .lrclk (CODEC_LRCLK)
  );

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // Host holding lock 0 and DSP waiting, with host request low in that same cycle
  sequence s_wait_host0;
    s_r.pend[0] && s_r.host_own[0] && !lock_wr[0];
  endsequence
  sequence s_host_drop0;
    !HOST_LOCK_REQ[0];
  endsequence

  a_clk_write_store: assert property (clk_wr |=> s_r.ctl == ($past(IO_WDATA) & 8'h9F))
    else $error("clock register did not store write");
  a_clk_rsvd_zero: assert property ((IO_RD && IO_ADDR == `CCS_ADDR_CLK) |=> IO_RDATA[6:5] == 2'b00)
    else $error("reserved clock bits not zero");
  a_lock_rsvd_zero: assert property ((IO_RD && IO_ADDR[15:1] == 15'h0003) |=> IO_RDATA[7:1] == 7'h00)
    else $error("reserved lock bits not zero");
  a_lock_read_own: assert property (
    (IO_RD && IO_ADDR == `CCS_ADDR_LOCK1) |=> IO_RDATA[0] == $past(s_r.dsp_own[1]))
    else $error("lock bit does not show DSP ownership");
  // Ownership moves in the very cycle the host grant falls, so no gap and no overlap
  a_lock_handover: assert property (
    (s_wait_host0 and s_host_drop0) |=> s_r.dsp_own[0] && !HOST_LOCK_GRANT[0])
    else $error("waiting request not granted on host release");
  a_lock_release: assert property ((lock_wr[0] && !IO_WDATA[0]) |=> !s_r.dsp_own[0] && !s_r.pend[0])
    else $error("write of 0 did not release lock");
  a_no_double_grant: assert property (!(|(s_r.dsp_own & s_r.host_own)))
    else $error("lock held by both parties");
  a_tie_dsp_wins: assert property (
    (lock_wr[1] && IO_WDATA[0] && !s_r.dsp_own[1] && !s_r.host_own[1] && HOST_LOCK_REQ[1])
    |=> s_r.dsp_own[1] && !HOST_LOCK_GRANT[1])
    else $error("tie not won by DSP");
endmodule : ccs_regs

/* test/ccs_host_model.sv */
// Host-side partner: lock requester and the two oscillator sources.
// Assumes the bench sets want; sources are scaled down, periods in CLOCK cycles.
`timescale 1ns/1ps
module ccs_host_model #(
  parameter int P_A = 8,  // Slower source period, scaled to stay below CLOCK/2
  parameter int P_B = 6   // Faster source period, scaled the same way
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] want,
  output logic      [1:0] req,
  output logic            osc_a,
  output logic            osc_b
);
  int n;  // Free-running cycle count behind both sources
  ////////////////////////////////////////////////////////////////////////////
  // Request follows want just after the edge; the grant plays no part
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= 2'h0;
      n   <= 0;
    end else begin
      req <= #1 want;
      n   <= #1 n + 1;
    end
  end
  // Square waves; sampled inputs, so no edge lands on the sampling edge
  assign osc_a = (n % P_A) < (P_A / 2);
  assign osc_b = (n % P_B) < (P_B / 2);
endmodule : ccs_host_model

/* test/test_ccs_regs.sv */
// Self-checking bench for the codec clock and lock register bank.
// Assumes the host model supplies the lock requests and both sources.
`timescale 1ns/1ps
module test_ccs_regs;
  logic        clock, reset_n, io_wr, io_rd, osc_a, osc_b, mclk, sclk, lrclk;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, d;
  logic [1:0]  want, req, grant;
  int          miscompares, n_compared, t;
  logic [7:0]  cfg [8] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h04, 8'h81, 8'h83, 8'h14};
  int          exp_p [8] = '{8, 16, 24, 16, 32, 6, 18, 96};  // MCLK period in cycles
  ccs_regs uut (.CLOCK(clock), .RESET_N(reset_n), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata), .OSC_24M(osc_a), .OSC_33M(osc_b),
    .HOST_LOCK_REQ(req), .HOST_LOCK_GRANT(grant), .CODEC_MCLK(mclk), .CODEC_SCLK(sclk),
    .CODEC_LRCLK(lrclk));
  ccs_host_model host (.clk(clock), .rst_n(reset_n), .want(want), .req(req), .osc_a(osc_a),
    .osc_b(osc_b));
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobes, launched 1 ns after the edge
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock) #1;
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge clock) #1;
    io_wr = 1'b0;
  endtask : wr
  // Data registered at the taking edge and held, so read a cycle later
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clock) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clock) #1;
    io_rd = 1'b0;
    @(posedge clock) #1;
    v = io_rdata;
  endtask : rd
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chkn
  function automatic logic pick(input int s);
    return (s == 0) ? mclk : ((s == 1) ? sclk : lrclk);
  endfunction : pick
  // Period between 2nd and 3rd rise; the first period after a change may be short
  task automatic period(input int s, output int c);
    logic p;
    int   r;
    r = 0;
    c = 0;
    p = pick(s);
    while (r < 3 && c < 5000) begin
      @(posedge clock) #2;
      if (r == 2) c++;
      if (pick(s) === 1'b1 && p !== 1'b1) r++;
      p = pick(s);
    end
  endtask : period
  task automatic wrap_up();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Watchdog: tests take about 90 us
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  initial begin
    {reset_n, io_wr, io_rd, io_addr, io_wdata, want} = '0;
    repeat (3) @(posedge clock);
    #1 reset_n = 1'b1;
    // Reset values, unmapped address 8 included
    for (int a = 5; a < 9; a++) begin
      rd(16'(a), d);
      chk8("reset", 8'h00, d);
    end
    wr(16'h0005, 8'hFF);
    wr(16'h0105, 8'h00);  // Unmapped alias must be ignored
    rd(16'h0005, d);
    chk8("clk reg", 8'h9F, d);
    wr(16'h0006, 8'hFF);
    rd(16'h0006, d);
    chk8("lock0 own", 8'h01, d);
    wr(16'h0006, 8'h00);
    rd(16'h0006, d);
    chk8("lock0 free", 8'h00, d);
    // Host owns lock1, DSP request waits, then takes over on release
    // Waits end 1 ns past the edge, so want never moves on a sampling edge
    want = 2'b10;
    repeat (3) @(posedge clock) #1;
    chk8("grant", 8'h02, {6'h00, grant});
    wr(16'h0007, 8'h01);
    rd(16'h0007, d);
    chk8("lock1 pend", 8'h00, d);
    want = 2'b00;
    repeat (3) @(posedge clock) #1;
    rd(16'h0007, d);
    chk8("lock1 take", 8'h01, d);
    want = 2'b10;
    repeat (3) @(posedge clock) #1;
    chk8("no double", 8'h00, {6'h00, grant});
    wr(16'h0007, 8'h00);
    repeat (3) @(posedge clock) #1;
    chk8("regrant", 8'h02, {6'h00, grant});
    // Cancel a pending request on lock0 before the host lets go
    want = 2'b01;
    repeat (3) @(posedge clock) #1;
    wr(16'h0006, 8'h01);
    wr(16'h0006, 8'h00);
    want = 2'b00;
    repeat (3) @(posedge clock) #1;
    rd(16'h0006, d);
    chk8("cancel", 8'h00, d);
    // Lock0 request waits on the host, then takes over on release
    want = 2'b01;
    repeat (3) @(posedge clock) #1;
    wr(16'h0006, 8'h01);
    want = 2'b00;
    repeat (3) @(posedge clock) #1;
    rd(16'h0006, d);
    chk8("lock0 take", 8'h01, d);
    chk8("lock0 host", 8'h00, {6'h00, grant});
    wr(16'h0006, 8'h00);
    // Host request and DSP write reach a free lock1 at the same edge
    want = 2'b10;
    wr(16'h0007, 8'h01);
    rd(16'h0007, d);
    chk8("tie own", 8'h01, d);
    chk8("tie host", 8'h00, {6'h00, grant});
    wr(16'h0007, 8'h00);
    repeat (3) @(posedge clock) #1;
    chk8("tie regrant", 8'h02, {6'h00, grant});
    want = 2'b00;
    // Every route, both sources, several divisors
    for (int i = 0; i < 8; i++) begin
      wr(16'h0005, cfg[i]);
      period(0, t);
      chkn("mclk", exp_p[i], t);
    end
    wr(16'h0005, 8'h81);
    period(1, t);
    chkn("sclk", 24, t);
    period(2, t);
    chkn("lrclk", 1536, t);
    wrap_up();
  end
endmodule : test_ccs_regs
